// [eph_basic_control.sv]
// Basic control register of the emulated PHY and the host-side effects it steers.
// Assumes the host MAC, fabric, loader and management ports are on CLK; the strap is a pin.
`timescale 1ns/1ns
`default_nettype none
module eph_basic_control #(
    parameter int DATA_W = 4
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic [11:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    input wire logic LOADER_WR,
    input wire logic [15:0] LOADER_WDATA,
    input wire logic [4:0] PHY_ADDR_STRAP,
    input wire logic [4:0] MII_PHY_ADDR,
    input wire logic [4:0] MII_REG_INDEX,
    input wire logic MII_WR,
    input wire logic MII_RD,
    input wire logic [15:0] MII_WDATA,
    output logic [15:0] MII_RDATA,
    output logic MII_ACK,
    input wire logic HOST_TX_EN,
    input wire logic [DATA_W-1:0] HOST_TXD,
    output logic HOST_RX_DV,
    output logic [DATA_W-1:0] HOST_RXD,
    output logic HOST_COL,
    input wire logic FABRIC_RX_DV,
    input wire logic [DATA_W-1:0] FABRIC_RXD,
    output logic FABRIC_TX_EN,
    output logic [DATA_W-1:0] FABRIC_TXD,
    output logic LINK_SPEED_100,
    output logic LINK_FULL_DUPLEX
);
    logic [15:0] ctrl;
    logic [15:0] next_ctrl;
    logic [4:0] strap_meta;
    logic [4:0] strap_sync;
    logic [4:0] phy_addr;
    logic [4:0] next_phy_addr;
    logic strap_taken;
    logic [1:0] strap_fill;
    logic refresh;
    logic next_refresh;
    logic host_hit;
    logic mii_hit;
    logic [31:0] next_reg_rdata;
    logic [15:0] next_mii_rdata;
    logic next_mii_ack;
    logic next_host_rx_dv;
    logic [DATA_W-1:0] next_host_rxd;
    logic next_host_col;
    logic next_fabric_tx_en;
    logic [DATA_W-1:0] next_fabric_txd;
    eph_res_if res_bus ();

    assign host_hit = (REG_ADDR == eph_pkg::CTRL_OFFSET);
    assign mii_hit = strap_taken && (MII_PHY_ADDR == phy_addr) && (MII_REG_INDEX == eph_pkg::CTRL_INDEX);

    always_comb
    begin
        // Self-clearing bits stay high until the next cycle with CE set, then drop.
        next_ctrl = ctrl & eph_pkg::CTRL_STORE_MASK;
        next_refresh = ctrl[eph_pkg::RESTART_BIT] || ctrl[eph_pkg::SOFT_RESET_BIT];
        if (ctrl[eph_pkg::SOFT_RESET_BIT])
            next_ctrl = eph_pkg::CTRL_RESET;
        if (REG_WR && host_hit)
            next_ctrl = REG_WDATA[15:0] & (eph_pkg::CTRL_STORE_MASK | eph_pkg::CTRL_SC_MASK);
        else if (MII_WR && mii_hit)
            next_ctrl = MII_WDATA & (eph_pkg::CTRL_STORE_MASK | eph_pkg::CTRL_SC_MASK);
        // The loader has the last word over any write in the same cycle.
        if (LOADER_WR)
            next_ctrl = LOADER_WDATA & (eph_pkg::CTRL_STORE_MASK | eph_pkg::CTRL_SC_MASK);
        next_phy_addr = strap_taken ? phy_addr : strap_sync;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            ctrl <= eph_pkg::CTRL_RESET;
            refresh <= 1'b0;
            strap_meta <= 5'h00;
            strap_sync <= 5'h00;
            phy_addr <= 5'h00;
            strap_taken <= 1'b0;
            strap_fill <= 2'b00;
        end
        else if (CE)
        begin
            ctrl <= next_ctrl;
            refresh <= next_refresh;
            strap_meta <= PHY_ADDR_STRAP;
            strap_sync <= strap_meta;
            phy_addr <= next_phy_addr;
            // The address is frozen only once both synchroniser stages hold the pin value.
            strap_fill <= {strap_fill[0], 1'b1};
            strap_taken <= strap_fill[1];
        end
    end

    always_comb
    begin
        next_reg_rdata = 32'h00000000;
        if (REG_RD && host_hit)
            next_reg_rdata = {eph_pkg::PAD_ZERO, ctrl};
        next_mii_ack = (MII_RD || MII_WR) && mii_hit;
        next_mii_rdata = (MII_RD && mii_hit) ? ctrl : 16'h0000;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            REG_RDATA <= 32'h00000000;
            MII_RDATA <= 16'h0000;
            MII_ACK <= 1'b0;
        end
        else if (CE)
        begin
            REG_RDATA <= next_reg_rdata;
            MII_RDATA <= next_mii_rdata;
            MII_ACK <= next_mii_ack;
        end
    end

    always_comb
    begin
        // Collision test is honoured outside loopback as well.
        next_host_col = ctrl[eph_pkg::COL_TEST_BIT] && HOST_TX_EN;
        if (ctrl[eph_pkg::LOOPBACK_BIT])
        begin
            next_host_rx_dv = HOST_TX_EN;
            next_host_rxd = HOST_TXD;
            next_fabric_tx_en = 1'b0;
        end
        else
        begin
            next_host_rx_dv = FABRIC_RX_DV;
            next_host_rxd = FABRIC_RXD;
            next_fabric_tx_en = HOST_TX_EN;
        end
        next_fabric_txd = next_fabric_tx_en ? HOST_TXD : '0;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            HOST_RX_DV <= 1'b0;
            HOST_RXD <= '0;
            HOST_COL <= 1'b0;
            FABRIC_TX_EN <= 1'b0;
            FABRIC_TXD <= '0;
        end
        else if (CE)
        begin
            HOST_RX_DV <= next_host_rx_dv;
            HOST_RXD <= next_host_rxd;
            HOST_COL <= next_host_col;
            FABRIC_TX_EN <= next_fabric_tx_en;
            FABRIC_TXD <= next_fabric_txd;
        end
    end

    assign res_bus.an_enable = ctrl[eph_pkg::AUTONEG_BIT];
    assign res_bus.forced_speed = ctrl[eph_pkg::SPEED_BIT];
    assign res_bus.forced_duplex = ctrl[eph_pkg::DUPLEX_BIT];
    assign res_bus.refresh = refresh;
    assign LINK_SPEED_100 = res_bus.speed_100;
    assign LINK_FULL_DUPLEX = res_bus.full_duplex;

    eph_resolve u_resolve (
        .clk(CLK),
        .reset(RESET),
        .ce(CE),
        .bus(res_bus.res)
    );

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    sequence loader_write_s;
        CE && LOADER_WR;
    endsequence
    sequence soft_reset_s;
        CE && ctrl[eph_pkg::SOFT_RESET_BIT] && !LOADER_WR && !REG_WR && !MII_WR;
    endsequence

    loader_wins_a: assert property (loader_write_s |=> ctrl == ($past(LOADER_WDATA)
        & (eph_pkg::CTRL_STORE_MASK | eph_pkg::CTRL_SC_MASK))) else $error("Loader value not taken.");
    soft_reset_a: assert property (soft_reset_s |=> ctrl == eph_pkg::CTRL_RESET)
        else $error("Soft reset did not restore defaults.");
    sc_clear_a: assert property (CE && (ctrl & eph_pkg::CTRL_SC_MASK) != 16'h0000 && !LOADER_WR && !REG_WR
        && !MII_WR |=> (ctrl & eph_pkg::CTRL_SC_MASK) == 16'h0000) else $error("Self-clear failed.");
    loop_path_a: assert property (CE && ctrl[eph_pkg::LOOPBACK_BIT] |=> !FABRIC_TX_EN
        && HOST_RX_DV == $past(HOST_TX_EN)) else $error("Loopback path wrong.");
    col_test_a: assert property (CE |=> HOST_COL == ($past(ctrl[eph_pkg::COL_TEST_BIT]) && $past(HOST_TX_EN)))
        else $error("Collision indication wrong.");
    restart_pulse_a: assert property (CE && ctrl[eph_pkg::RESTART_BIT] |=> refresh)
        else $error("Restart not passed on.");
    inert_bits_a: assert property (ctrl[eph_pkg::UPPER_SPEED_BIT] == 1'b0 && ctrl[5:0] == 6'h00)
        else $error("Read-only bits set.");
    host_read_a: assert property (CE && REG_RD && host_hit |=> REG_RDATA[31:16] == 16'h0000
        && REG_RDATA[15:0] == $past(ctrl)) else $error("Register read wrong.");
    mii_addr_a: assert property (CE && (MII_RD || MII_WR) && MII_PHY_ADDR != phy_addr |=> !MII_ACK)
        else $error("Answered foreign address.");
    inert_write_a: assert property (CE && REG_WR && host_hit && !LOADER_WR |=> ctrl[eph_pkg::POWER_DOWN_BIT]
        == $past(REG_WDATA[11]) && ctrl[eph_pkg::ISOLATE_BIT] == $past(REG_WDATA[10]))
        else $error("Inert bits not stored.");
endmodule
`default_nettype wire

// [eph_basic_control_tb.sv]
// Self-checking bench for the emulated PHY basic control register.
// Assumes a fixed nonzero strap address; CE drops once to check that state freezes.
`timescale 1ns/1ns
`default_nettype none
module eph_basic_control_tb;
    localparam logic [11:0] OFF = eph_pkg::CTRL_OFFSET;
    logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, loader_wr = 1'b0;
    logic mii_wr = 1'b0, mii_rd = 1'b0, send = 1'b0, fab_dv = 1'b0, mii_ack, tx_en;
    logic host_rx_dv, host_col, fabric_tx_en, link_speed_100, link_full_duplex;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [15:0] loader_wdata = 16'h0, mii_wdata = 16'h0, mii_rdata;
    logic [4:0] mii_phy_addr = 5'h00, mii_reg_index = 5'h00;
    logic [4:0] strap = 5'h0b;
    logic ce = 1'b1;
    logic [3:0] fab_d = 4'h0, txd, host_rxd, fabric_txd;
    int err_count = 0, checked = 0, cycles = 0;
    always #5 clk = ~clk;
    eph_mac_model i_mac (.clk(clk), .send(send), .tx_en(tx_en), .txd(txd));
    eph_basic_control #(.DATA_W(4)) i_dut (.CLK(clk), .RESET(reset), .CE(ce), .REG_ADDR(reg_addr),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .LOADER_WR(loader_wr), .LOADER_WDATA(loader_wdata), .PHY_ADDR_STRAP(strap),
        .MII_PHY_ADDR(mii_phy_addr), .MII_REG_INDEX(mii_reg_index), .MII_WR(mii_wr), .MII_RD(mii_rd),
        .MII_WDATA(mii_wdata), .MII_RDATA(mii_rdata), .MII_ACK(mii_ack), .HOST_TX_EN(tx_en),
        .HOST_TXD(txd), .HOST_RX_DV(host_rx_dv), .HOST_RXD(host_rxd), .HOST_COL(host_col),
        .FABRIC_RX_DV(fab_dv), .FABRIC_RXD(fab_d), .FABRIC_TX_EN(fabric_tx_en), .FABRIC_TXD(fabric_txd),
        .LINK_SPEED_100(link_speed_100), .LINK_FULL_DUPLEX(link_full_duplex));
    task automatic wrap_up();
        $display("errors %0d, comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic reg_op(input logic [11:0] a, input logic w, input logic [31:0] d, input logic ld);
        @(posedge clk);
        reg_addr <= a;
        reg_wr <= w;
        reg_rd <= ~w;
        reg_wdata <= d;
        loader_wr <= ld;
        loader_wdata <= 16'h2100;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        loader_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        reg_op(a, 1'b0, 32'h0, 1'b0);
        check(reg_rdata, exp, "register read");
    endtask
    task automatic link(input logic [1:0] exp);
        repeat (4) @(posedge clk);
        #1;
        check({link_speed_100, link_full_duplex}, exp, "link mode");
    endtask
    task automatic mii_op(input logic [4:0] pa, input logic [4:0] ix, input logic w, input logic [15:0] d,
        input logic ack, input logic [15:0] exp);
        @(posedge clk);
        mii_phy_addr <= pa;
        mii_reg_index <= ix;
        mii_wr <= w;
        mii_rd <= ~w;
        mii_wdata <= d;
        @(posedge clk);
        mii_wr <= 1'b0;
        mii_rd <= 1'b0;
        #1;
        check(mii_ack, ack, "management ack");
        check(mii_rdata, exp, "management data");
    endtask
    task automatic t_reset();
        rd(OFF, 32'h1000);
        link(2'b11);
    endtask
    task automatic t_fields();
        reg_op(OFF, 1'b1, 32'hffff7dff, 1'b0);
        repeat (3) @(posedge clk);
        rd(OFF, 32'h7d80);
        rd(12'h1c4, 32'h0);
    endtask
    task automatic t_forced();
        for (int i = 0; i < 4; i++)
        begin
            reg_op(OFF, 1'b1, {18'h0, i[1], 4'h0, i[0], 8'h00}, 1'b0);
            link(i[1:0]);
        end
        reg_op(OFF, 1'b1, 32'h1000, 1'b0);
        link(2'b11);
    endtask
    task automatic t_path(input logic lb, input logic col);
        logic pe, pf;
        logic [3:0] pd, pfd;
        // The collision test is only enabled together with loopback.
        reg_op(OFF, 1'b1, {17'h0, lb, 6'h04, col & lb, 7'h00}, 1'b0);
        for (int i = 0; i < 7; i++)
        begin
            @(posedge clk);
            send <= (i < 4);
            fab_dv <= 1'b1;
            fab_d <= i[3:0] ^ 4'h5;
            #1;
            if (i > 0 && lb)
            begin
                check(host_rx_dv, pe, "loop valid");
                check(host_rxd, pd, "loop data");
                check(fabric_tx_en, 1'b0, "fabric idle");
            end
            if (i > 0 && !lb)
            begin
                check(fabric_tx_en, pe, "fabric valid");
                if (pe)
                    check(fabric_txd, pd, "fabric data");
                check({host_rx_dv, host_rxd}, {pf, pfd}, "receive path");
            end
            if (i > 0)
                check(host_col, pe & col & lb, "collision");
            pe = tx_en;
            pd = txd;
            pf = fab_dv;
            pfd = fab_d;
        end
        @(posedge clk);
        fab_dv <= 1'b0;
    endtask
    task automatic t_selfclr();
        reg_op(OFF, 1'b1, 32'he480, 1'b0);
        repeat (3) @(posedge clk);
        rd(OFF, 32'h1000);
        link(2'b11);
        reg_op(OFF, 1'b1, 32'h0300, 1'b0);
        repeat (3) @(posedge clk);
        rd(OFF, 32'h0100);
        link(2'b01);
    endtask
    task automatic t_loader();
        reg_op(OFF, 1'b1, 32'h4000, 1'b1);
        rd(OFF, 32'h2100);
    endtask
    task automatic t_mii();
        mii_op(5'h0b, 5'h00, 1'b0, 16'h0, 1'b1, 16'h2100);
        mii_op(5'h00, 5'h00, 1'b0, 16'h0, 1'b0, 16'h0);
        mii_op(5'h0b, 5'h01, 1'b0, 16'h0, 1'b0, 16'h0);
        mii_op(5'h0b, 5'h00, 1'b1, 16'h1100, 1'b1, 16'h0);
        mii_op(5'h00, 5'h00, 1'b1, 16'h4000, 1'b0, 16'h0);
        rd(OFF, 32'h1100);
    endtask
    task automatic t_hold();
        // A write presented while the clock enable is low must leave the register alone.
        @(posedge clk);
        ce <= 1'b0;
        reg_op(OFF, 1'b1, 32'h4000, 1'b0);
        @(posedge clk);
        ce <= 1'b1;
        rd(OFF, 32'h1100);
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            wrap_up();
        end
    end
    initial
    begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset();
        t_fields();
        t_forced();
        t_path(1'b1, 1'b1);
        t_path(1'b0, 1'b0);
        t_path(1'b1, 1'b0);
        t_selfclr();
        t_loader();
        t_mii();
        t_hold();
        wrap_up();
    end
endmodule
`default_nettype wire

// [eph_mac_model.sv]
// Behavioural host MAC transmitter facing the emulated PHY.
// Assumes it shares CLK with the block; send is driven by the bench.
`timescale 1ns/1ns
`default_nettype none
module eph_mac_model (
    input wire logic clk,
    input wire logic send,
    output logic tx_en,
    output logic [3:0] txd
);
    initial tx_en = 1'b0;
    initial txd = 4'h0;
    // Outside a frame the nibble lines toggle so stale data never looks valid.
    always @(posedge clk)
    begin
        tx_en <= send;
        txd <= send ? txd + 4'h1 : ~txd;
    end
endmodule
`default_nettype wire

// [eph_pkg.sv]
// Constants shared by the emulated PHY basic control block.
// Assumes a 12-bit byte address on the memory-mapped register port.
package eph_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] CTRL_OFFSET = 12'h1c0;
    localparam logic [4:0] CTRL_INDEX = 5'h00;
    localparam int SOFT_RESET_BIT = 15;
    localparam int LOOPBACK_BIT = 14;
    localparam int SPEED_BIT = 13;
    localparam int AUTONEG_BIT = 12;
    localparam int POWER_DOWN_BIT = 11;
    localparam int ISOLATE_BIT = 10;
    localparam int RESTART_BIT = 9;
    localparam int DUPLEX_BIT = 8;
    localparam int COL_TEST_BIT = 7;
    localparam int UPPER_SPEED_BIT = 6;
    localparam logic [15:0] CTRL_RESET = 16'h1000;
    localparam logic [15:0] CTRL_STORE_MASK = 16'h7d80;
    localparam logic [15:0] CTRL_SC_MASK = 16'h8200;
    localparam logic [15:0] PAD_ZERO = 16'h0000;
    typedef enum logic [1:0] {
        EPH_RES_IDLE = 2'b00,
        EPH_RES_RUN = 2'b01,
        EPH_RES_DONE = 2'b10
    } eph_res_state_t;
endpackage

// [eph_res_if.sv]
// Signals between the control register and the link-mode resolver.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface eph_res_if;
    logic an_enable;
    logic forced_speed;
    logic forced_duplex;
    logic refresh;
    logic speed_100;
    logic full_duplex;
    logic an_done;
    modport ctl (output an_enable, output forced_speed, output forced_duplex, output refresh,
        input speed_100, input full_duplex, input an_done);
    modport res (input an_enable, input forced_speed, input forced_duplex, input refresh,
        output speed_100, output full_duplex, output an_done);
endinterface
`default_nettype wire

// [eph_resolve.sv]
// Emulated link-mode resolver: forced or negotiated speed and duplex.
// Assumes refresh is a one-cycle pulse from the control register.
`timescale 1ns/1ns
`default_nettype none
module eph_resolve #(
    parameter logic NEG_SPEED_100 = 1'b1,
    parameter logic NEG_FULL_DUPLEX = 1'b1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    eph_res_if.res bus
);
    eph_pkg::eph_res_state_t state;
    eph_pkg::eph_res_state_t next_state;
    logic neg_speed;
    logic neg_duplex;
    logic next_neg_speed;
    logic next_neg_duplex;
    logic next_speed_100;
    logic next_full_duplex;

    always_comb
    begin
        next_state = state;
        next_neg_speed = neg_speed;
        next_neg_duplex = neg_duplex;
        case (state)
            eph_pkg::EPH_RES_IDLE: next_state = eph_pkg::EPH_RES_RUN;
            eph_pkg::EPH_RES_RUN:
            begin
                // Negotiation result against the emulated partner is fixed.
                next_neg_speed = NEG_SPEED_100;
                next_neg_duplex = NEG_FULL_DUPLEX;
                next_state = eph_pkg::EPH_RES_DONE;
            end
            eph_pkg::EPH_RES_DONE: if (bus.refresh) next_state = eph_pkg::EPH_RES_RUN;
            default: next_state = eph_pkg::EPH_RES_IDLE;
        endcase
        if (bus.refresh)
            next_state = eph_pkg::EPH_RES_RUN;
        // Forced bits only count with negotiation off.
        next_speed_100 = bus.an_enable ? next_neg_speed : bus.forced_speed;
        next_full_duplex = bus.an_enable ? next_neg_duplex : bus.forced_duplex;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state <= eph_pkg::EPH_RES_IDLE;
            neg_speed <= 1'b0;
            neg_duplex <= 1'b0;
            bus.speed_100 <= 1'b0;
            bus.full_duplex <= 1'b0;
            bus.an_done <= 1'b0;
        end
        else if (ce)
        begin
            state <= next_state;
            neg_speed <= next_neg_speed;
            neg_duplex <= next_neg_duplex;
            bus.speed_100 <= next_speed_100;
            bus.full_duplex <= next_full_duplex;
            bus.an_done <= (next_state == eph_pkg::EPH_RES_DONE);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    forced_mode_a: assert property (ce && !bus.an_enable |=> bus.speed_100 == $past(bus.forced_speed)
        && bus.full_duplex == $past(bus.forced_duplex)) else $error("Forced mode not applied.");
    neg_mode_a: assert property (ce && bus.an_enable && state == eph_pkg::EPH_RES_DONE && !bus.refresh
        |=> bus.speed_100 == NEG_SPEED_100) else $error("Negotiated speed not applied.");
    refresh_run_a: assert property (ce && bus.refresh |=> state == eph_pkg::EPH_RES_RUN)
        else $error("Restart did not rerun negotiation.");
endmodule
`default_nettype wire
